// [test/fll_filter_checker.sv]
// Assertions on the filter block ports
`timescale 1ns/1ns
module fll_filter_checker (
   input wire logic                 clk_in,
   input wire logic                 rst_in,
   input wire fll_pkg::fll_sample_s sample_in,
   input wire fll_pkg::fll_sample_s level_out,
   input wire fll_pkg::fll_nvm_s    nvm_out,
   input wire logic                 nvm_ready_in,
   input wire logic                 s_axi_rvalid_out,
   input wire logic                 s_axi_rready_in,
   input wire logic [31:0]          s_axi_rdata_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   AST_LAT: assert property (sample_in.valid |-> ##2 level_out.valid)
      else $error("output late");
   AST_ONE: assert property (level_out.valid |-> $past(sample_in.valid, 2))
      else $error("output without sample");
   AST_HOLD: assert property (!level_out.valid |-> $stable(level_out.level))
      else $error("level moved between outputs");
   AST_NVMH: assert property (nvm_out.valid && !nvm_ready_in |=> nvm_out.valid && $stable(nvm_out.data))
      else $error("store word dropped");
   AST_NVMA: assert property (nvm_out.valid |-> nvm_out.addr < 5'h1e || nvm_out.addr == 5'h1f)
      else $error("store address out of table");
   AST_HDR: assert property (nvm_out.valid && nvm_out.addr == 5'h1f |-> nvm_out.data <= 32'h1e)
      else $error("count above limit");
   AST_ENT: assert property (nvm_out.valid && nvm_out.addr != 5'h1f |-> nvm_out.data[15:12] == 4'h0)
      else $error("entry format");
   AST_RDH: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
      else $error("read data dropped");
endmodule : fll_filter_checker

// [test/fll_nvm_model.sv]
// Non-volatile store at the far side of the commit port
`timescale 1ns/1ns
module fll_nvm_model (
   input  wire logic              clk_in,
   input  wire logic              rst_in,
   input  wire fll_pkg::fll_nvm_s nvm_in,
   output logic                   ready_out
);
   logic [31:0] mem [32];
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) ready_out <= 1'b0;
      else begin
         ready_out <= 1'($urandom);
         if (nvm_in.valid && ready_out) mem[nvm_in.addr] <= nvm_in.data;
      end
   end
endmodule : fll_nvm_model

// [test/testbench.sv]
// Self-checking bench for the fuel level filter block
`timescale 1ns/1ns
module testbench;
   import fll_pkg::*;
   logic clk_in, rst_in, awv, wv, bry, arv, rry, nrdy, irq, stab, awr, wrd, bv, arr, rv;
   logic [7:0] aw, ar;
   logic [31:0] wd, rdat, d;
   logic [1:0] br, rr, rsp;
   logic [11:0] v [3];
   fll_sample_s smp_q, lo;
   fll_nvm_s nv;
   int failures = 0, num_checks = 0, cyc = 0;
   fll_filter_top #(.SAMPLES_PER_S(1), .STAB_DELTA(2), .STAB_SAMPLES(2)) dut (.clk_in(clk_in), .rst_in(rst_in),
      .s_axi_awaddr_in(aw), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
      .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd), .s_axi_bresp_out(br),
      .s_axi_bvalid_out(bv), .s_axi_bready_in(bry), .s_axi_araddr_in(ar), .s_axi_arvalid_in(arv),
      .s_axi_arready_out(arr), .s_axi_rdata_out(rdat), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv),
      .s_axi_rready_in(rry), .sample_in(smp_q), .level_out(lo), .stable_out(stab), .nvm_out(nv),
      .nvm_ready_in(nrdy), .irq_out(irq));
   fll_nvm_model nvm (.clk_in(clk_in), .rst_in(rst_in), .nvm_in(nv), .ready_out(nrdy));
   initial begin clk_in = 0; forever #20 clk_in = ~clk_in; end
   always @(posedge clk_in) begin cyc++; if (cyc > 9000) begin failures++; print_verdict; end end
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      num_checks++;
      if (s !== e) begin failures++; $display("mismatch %s exp %h seen %h", n, e, s); end
   endtask : chk
   task automatic print_verdict;
      if (failures == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict
   task automatic wr(logic [7:0] a, logic [31:0] x);
      logic ad, dd;
      ad = 0; dd = 0;
      @(posedge clk_in);
      aw <= a; wd <= x; awv <= 1; wv <= 1; bry <= 1;
      while (!(ad && dd)) begin
         @(posedge clk_in);
         if (awr && !ad) begin ad = 1; awv <= 0; end
         if (wrd && !dd) begin dd = 1; wv <= 0; end
      end
      while (!bv) @(posedge clk_in);
      rsp = br; bry <= 0;
   endtask : wr
   task automatic rd(logic [7:0] a);
      @(posedge clk_in);
      ar <= a; arv <= 1; rry <= 1;
      do @(posedge clk_in); while (!arr);
      arv <= 0;
      while (!rv) @(posedge clk_in);
      d = rdat; rsp = rr; rry <= 0;
   endtask : rd
   task automatic smp(logic [11:0] x);
      @(posedge clk_in);
      smp_q <= {1'b1, x};
      @(posedge clk_in);
      smp_q.valid <= 0;
      repeat (3) @(posedge clk_in);
   endtask : smp
   function automatic logic [11:0] med3(logic [11:0] a, b, c);
      return (a > b) ? ((b > c) ? b : (a > c ? c : a)) : ((a > c) ? a : (b > c ? c : b));
   endfunction : med3
   initial begin
      void'($urandom(32'h615132f6));
      {awv, wv, bry, arv, rry, aw, ar, wd, smp_q} = '0;
      rst_in = 1;
      repeat (12) @(posedge clk_in);
      rst_in <= 0;
      rd(OFS_CTRL); chk("ctrl", d, 0);
      rd(OFS_AVG); chk("avg", d, 32'h15);
      rd(OFS_MED); chk("med", d, 32'h7);
      wr(OFS_AVG, 32'h16); rd(OFS_AVG); chk("avg", d, 32'h15);
      wr(8'h34, 0); chk("bresp", rsp, RESP_SLVERR); rd(8'h34); chk("resp", rsp, RESP_SLVERR);
      for (int i = 0; i < 4; i++) begin v[0] = 12'($urandom); smp(v[0]); chk("raw", lo.level, v[0]); end
      repeat (6) smp(v[0]);
      chk("stable", stab, 1);
      wr(OFS_MASK, 32'h2);
      for (int i = 0; i < 31; i++) begin wr(OFS_CALVOL, i); wr(OFS_CALCMD, 32'h1); end
      rd(OFS_STATUS); chk("count", d[12:8], 30);
      chk("irq", irq, 1);
      rd(OFS_INT); chk("refused", d[1], 1);
      @(posedge clk_in); chk("irq", irq, 0);
      wr(OFS_CALCMD, 32'h2); rd(OFS_STATUS); chk("count", d[12:8], 29);
      wr(OFS_CALCMD, 32'h1); wr(OFS_CALCMD, 32'h8);
      repeat (300) @(posedge clk_in);
      chk("hdr", nvm.mem[31], 30);
      chk("newest", nvm.mem[29][31:16], 30);
      chk("lvl", nvm.mem[0][11:0], v[0]);
      rd(OFS_INT); chk("int", d, 32'hc);
      wr(OFS_CALCMD, 32'h4); rd(OFS_STATUS); chk("count", d[12:8], 0);
      smp(v[0] + 12'h100); chk("stable", stab, 0);
      wr(OFS_MED, 0); wr(OFS_CTRL, 2);
      for (int j = 0; j < 3; j++) begin v[j] = 12'($urandom); smp(v[j]); end
      chk("median", lo.level, med3(v[0], v[1], v[2]));
      wr(OFS_COVQ, 32'hffff); wr(OFS_COVR, 32'h1); wr(OFS_CTRL, 3);
      smp(v[0]); chk("adp", lo.level, v[0]);
      smp(v[1]); chk("adp", lo.level, v[0]);
      v[0] = 12'($urandom) & 12'hffe; v[1] = 12'($urandom) & 12'hffe;
      wr(OFS_AVG, 2); wr(OFS_CTRL, 1);
      repeat (2) begin smp(v[0]); smp(v[1]); end
      chk("avg", lo.level, 12'(({1'b0, v[0]} + v[1]) >> 1));
      print_verdict;
   end
endmodule : testbench
bind fll_filter_top fll_filter_checker chk_i (.clk_in(clk_in), .rst_in(rst_in), .sample_in(sample_in),
   .level_out(level_out), .nvm_out(nvm_out), .nvm_ready_in(nvm_ready_in), .s_axi_rvalid_out(s_axi_rvalid_out),
   .s_axi_rready_in(s_axi_rready_in), .s_axi_rdata_out(s_axi_rdata_out));

// [verilog/fll_adaptive.sv]
// Predictive estimator weighting new samples by the noise covariances
`timescale 1ns/1ns
module fll_adaptive (
   input  wire logic                      clk_in,
   input  wire logic                      rst_in,
   input  wire logic                      flush_in,
   input  wire fll_pkg::fll_sample_s      sample_in,
   input  wire logic [15:0]               cov_q_in,
   input  wire logic [15:0]               cov_r_in,
   output logic      [fll_pkg::LVL_W-1:0] est_out
);
   import fll_pkg::*;

   localparam int EW = LVL_W + ADP_FRAC;

   logic [EW-1:0]        est_q;
   logic                 init_q;
   logic [16:0]          cov_sum;
   logic [ADP_WSH:0]     weight;
   logic signed [EW:0]   err;
   logic signed [EW+ADP_WSH+1:0] step;

   assign cov_sum = 17'(cov_q_in) + 17'(cov_r_in);
   assign weight  = (cov_sum == 17'h0) ? (ADP_WSH+1)'(1 << ADP_WSH)
                  : (ADP_WSH+1)'((25'(cov_r_in) << ADP_WSH) / 25'(cov_sum));
   assign err     = $signed({1'b0, sample_in.level, {ADP_FRAC{1'b0}}}) - $signed({1'b0, est_q});
   assign step    = (err * $signed({1'b0, weight})) >>> ADP_WSH;
   assign est_out = est_q[EW-1:ADP_FRAC];

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         est_q  <= '0;
         init_q <= 1'b0;
      end else if (flush_in) begin
         init_q <= 1'b0;
      end else if (sample_in.valid) begin
         init_q <= 1'b1;
         if (!init_q)
            est_q <= {sample_in.level, {ADP_FRAC{1'b0}}};
         else
            est_q <= EW'($signed({1'b0, est_q}) + step);
      end
   end

endmodule : fll_adaptive

// [verilog/fll_filter_top.sv]
// Fuel level filter and calibration table with AXI4-Lite registers
// ---------------------------------------------------------------
// Overview of operation
// - Four filter modes are selectable: off, averaging, median and adaptive.
// - Off mode passes each raw sample straight to the output.
// - Averaging mode outputs the mean of the samples of the configured interval.
// - Median mode drops the lowest and highest samples of the window and averages the rest.
// - Adaptive mode blends the new sample with the predicted estimate.
// - The new sample's weight falls as Q over R grows.
// - Averaging time accepts 0 to 21 seconds, default 21, longer is slower.
// - Median length accepts 0 to 7 extra samples, default 7.
// - Filtering is off after reset until a mode is chosen.
// - The finish command writes the table to non-volatile memory.
// - A stability flag tells a settled level from a fluctuating one.
// - Delete removes the newest point of the table.
// - Clear erases every point of the table.
// - The table holds at most thirty points and refuses more.
// ---------------------------------------------------------------
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module fll_filter_top #(
   parameter int SAMPLES_PER_S = 10,
   parameter int STAB_DELTA    = 8,
   parameter int STAB_SAMPLES  = 10
) (
   input  wire logic                            clk_in,
   input  wire logic                            rst_in,
   input  wire logic [fll_pkg::ADDR_W-1:0]      s_axi_awaddr_in,
   input  wire logic                            s_axi_awvalid_in,
   output logic                                 s_axi_awready_out,
   input  wire logic [31:0]                     s_axi_wdata_in,
   input  wire logic [3:0]                      s_axi_wstrb_in,
   input  wire logic                            s_axi_wvalid_in,
   output logic                                 s_axi_wready_out,
   output logic [1:0]                           s_axi_bresp_out,
   output logic                                 s_axi_bvalid_out,
   input  wire logic                            s_axi_bready_in,
   input  wire logic [fll_pkg::ADDR_W-1:0]      s_axi_araddr_in,
   input  wire logic                            s_axi_arvalid_in,
   output logic                                 s_axi_arready_out,
   output logic [31:0]                          s_axi_rdata_out,
   output logic [1:0]                           s_axi_rresp_out,
   output logic                                 s_axi_rvalid_out,
   input  wire logic                            s_axi_rready_in,
   input  wire fll_pkg::fll_sample_s            sample_in,
   output fll_pkg::fll_sample_s                 level_out,
   output logic                                 stable_out,
   output fll_pkg::fll_nvm_s                    nvm_out,
   input  wire logic                            nvm_ready_in,
   output logic                                 irq_out
);
   import fll_pkg::*;

   typedef enum {CAL_IDLE, CAL_ENTRY, CAL_HDR} fll_cal_e;

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic                 aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
   logic [ADDR_W-1:0]    awaddr_q;
   logic [31:0]          wdata_q, rdata_q;
   logic [3:0]           wstrb_q;
   logic [1:0]           bresp_q, rresp_q;
   fll_mode_e            mode_q;
   logic [4:0]           avg_time_q;
   logic [2:0]           med_len_q;
   logic [15:0]          cov_q_q, cov_r_q, cal_vol_q;
   logic [INT_W-1:0]     int_q, mask_q, int_set;
   logic [CAL_IDX_W-1:0] cal_idx_q, cal_cnt_q, nvm_idx_q;
   logic [31:0]          cal_q [CAL_MAX];
   fll_cal_e             cal_st_q;
   fll_sample_s          level_q;
   fll_nvm_s             nvm_q;
   logic                 pend_q, stable_q, have_avg_q;
   logic [LVL_W-1:0]     raw_q, prev_raw_q, avg_q;
   logic [LVL_W+15:0]    acc_q;
   logic [15:0]          cnt_q;
   logic [7:0]           stab_cnt_q;

   logic                 wr_fire, ar_fire, int_rd;
   logic [31:0]          rd_mux, cq_m, cr_m, vol_m;
   logic                 rd_ok, wr_ok;
   logic                 cmd_wr, flush;
   logic                 do_add, do_del, do_clr, do_fin, refuse;
   logic [LVL_W-1:0]     med_out, adp_out, filt_level, raw_diff;
   logic [15:0]          avg_target;
   logic [LVL_W+15:0]    acc_next;
   logic                 stab_near;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) res[b*8 +: 8] = data[b*8 +: 8];
      end
      return res;
   endfunction : merge

   function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
      return (a <= OFS_CALDATA) && (a[1:0] == 2'h0);
   endfunction : reg_hit

   // ---------------------------------------------------------------
   // AXI4-Lite handshakes
   // ---------------------------------------------------------------
   assign s_axi_awready_out = !aw_hold_q && !bvalid_q;
   assign s_axi_wready_out  = !w_hold_q && !bvalid_q;
   assign s_axi_arready_out = !rvalid_q;
   assign s_axi_bvalid_out  = bvalid_q;
   assign s_axi_bresp_out   = bresp_q;
   assign s_axi_rvalid_out  = rvalid_q;
   assign s_axi_rdata_out   = rdata_q;
   assign s_axi_rresp_out   = rresp_q;
   assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
   assign ar_fire = s_axi_arvalid_in && !rvalid_q;
   assign wr_ok   = reg_hit(awaddr_q);
   assign rd_ok   = reg_hit(s_axi_araddr_in);
   assign int_rd  = ar_fire && (s_axi_araddr_in == OFS_INT);

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         rvalid_q  <= 1'b0;
         awaddr_q  <= '0;
         wdata_q   <= '0;
         wstrb_q   <= '0;
         bresp_q   <= RESP_OKAY;
         rdata_q   <= '0;
         rresp_q   <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_hold_q <= 1'b1;
            wdata_q  <= s_axi_wdata_in;
            wstrb_q  <= s_axi_wstrb_in;
         end
         if (wr_fire) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready_in) begin
            bvalid_q <= 1'b0;
         end
         if (ar_fire) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_q && s_axi_rready_in) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Read selection
   // ---------------------------------------------------------------
   always_comb begin
      unique case (s_axi_araddr_in)
         OFS_CTRL:    rd_mux = {30'h0, mode_q};
         OFS_AVG:     rd_mux = {27'h0, avg_time_q};
         OFS_MED:     rd_mux = {29'h0, med_len_q};
         OFS_COVQ:    rd_mux = {16'h0, cov_q_q};
         OFS_COVR:    rd_mux = {16'h0, cov_r_q};
         OFS_STATUS:  rd_mux = {16'h0, 2'h0, (cal_st_q != CAL_IDLE), cal_cnt_q, 7'h0, stable_q};
         OFS_INT:     rd_mux = {28'h0, int_q};
         OFS_MASK:    rd_mux = {28'h0, mask_q};
         OFS_CALVOL:  rd_mux = {16'h0, cal_vol_q};
         OFS_LEVEL:   rd_mux = {20'h0, level_q.level};
         OFS_CALIDX:  rd_mux = {27'h0, cal_idx_q};
         OFS_CALDATA: rd_mux = (cal_idx_q < cal_cnt_q) ? cal_q[cal_idx_q] : 32'h0;
         default:     rd_mux = 32'h0;
      endcase
   end

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   assign cmd_wr = wr_fire && (awaddr_q == OFS_CALCMD) && wstrb_q[0];
   assign flush  = wr_fire && (awaddr_q <= OFS_MED) && wr_ok;
   assign cq_m   = merge({16'h0, cov_q_q}, wdata_q, wstrb_q);
   assign cr_m   = merge({16'h0, cov_r_q}, wdata_q, wstrb_q);
   assign vol_m  = merge({16'h0, cal_vol_q}, wdata_q, wstrb_q);

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         mode_q     <= FLL_OFF;
         avg_time_q <= AVG_TIME_RST;
         med_len_q  <= MED_LEN_RST;
         cov_q_q    <= COV_RST;
         cov_r_q    <= COV_RST;
         mask_q     <= '0;
         cal_vol_q  <= '0;
         cal_idx_q  <= '0;
      end else if (wr_fire) begin
         unique case (awaddr_q)
            OFS_CTRL:   if (wstrb_q[0]) mode_q <= fll_mode_e'(wdata_q[1:0]);
            OFS_AVG: begin
               if (wstrb_q[0] && wdata_q[7:0] <= 8'(AVG_TIME_MAX_S)) avg_time_q <= wdata_q[4:0];
            end
            OFS_MED:    if (wstrb_q[0]) med_len_q <= wdata_q[2:0];
            OFS_COVQ:   cov_q_q   <= cq_m[15:0];
            OFS_COVR:   cov_r_q   <= cr_m[15:0];
            OFS_MASK:   if (wstrb_q[0]) mask_q <= wdata_q[INT_W-1:0];
            OFS_CALVOL: cal_vol_q <= vol_m[15:0];
            OFS_CALIDX: if (wstrb_q[0]) cal_idx_q <= wdata_q[CAL_IDX_W-1:0];
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Filters
   // ---------------------------------------------------------------
   fll_trim_mean #(.DEPTH(MED_DEPTH)) u_trim (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .flush_in (flush),
      .sample_in(sample_in),
      .len_in   (med_len_q),
      .mean_out (med_out)
   );

   fll_adaptive u_adp (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .flush_in (flush),
      .sample_in(sample_in),
      .cov_q_in (cov_q_q),
      .cov_r_in (cov_r_q),
      .est_out  (adp_out)
   );

   assign avg_target = 16'(avg_time_q) * 16'(SAMPLES_PER_S);
   assign acc_next   = acc_q + (LVL_W+16)'(sample_in.level);
   assign filt_level = (mode_q == FLL_AVG) ? (have_avg_q ? avg_q : raw_q)
                     : (mode_q == FLL_MED) ? med_out
                     : (mode_q == FLL_ADP) ? adp_out
                     : raw_q;
   assign raw_diff   = (raw_q > prev_raw_q) ? raw_q - prev_raw_q : prev_raw_q - raw_q;
   assign stab_near  = raw_diff <= LVL_W'(STAB_DELTA);

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         acc_q      <= '0;
         cnt_q      <= '0;
         avg_q      <= '0;
         have_avg_q <= 1'b0;
         raw_q      <= '0;
         prev_raw_q <= '0;
         pend_q     <= 1'b0;
         level_q    <= '0;
         stab_cnt_q <= '0;
         stable_q   <= 1'b0;
      end else begin
         pend_q        <= sample_in.valid;
         level_q.valid <= pend_q;
         if (pend_q) level_q.level <= filt_level;
         if (flush) begin
            acc_q      <= '0;
            cnt_q      <= '0;
            have_avg_q <= 1'b0;
         end else if (sample_in.valid) begin
            raw_q      <= sample_in.level;
            prev_raw_q <= raw_q;
            if (cnt_q + 16'h1 >= avg_target) begin
               avg_q      <= LVL_W'(acc_next / (LVL_W+16)'(cnt_q + 16'h1));
               have_avg_q <= 1'b1;
               acc_q      <= '0;
               cnt_q      <= '0;
            end else begin
               acc_q <= acc_next;
               cnt_q <= cnt_q + 16'h1;
            end
         end
         if (pend_q) begin
            if (!stab_near) begin
               stab_cnt_q <= '0;
               stable_q   <= 1'b0;
            end else if (stab_cnt_q < 8'(STAB_SAMPLES)) begin
               stab_cnt_q <= stab_cnt_q + 8'h1;
            end else begin
               stable_q <= 1'b1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Calibration table
   // ---------------------------------------------------------------
   assign do_add = cmd_wr && wdata_q[CMD_ADD] && !wdata_q[CMD_DEL] && !wdata_q[CMD_CLEAR] && (cal_st_q == CAL_IDLE);
   assign do_del = cmd_wr && wdata_q[CMD_DEL] && (cal_st_q == CAL_IDLE);
   assign do_clr = cmd_wr && wdata_q[CMD_CLEAR] && (cal_st_q == CAL_IDLE);
   assign do_fin = cmd_wr && wdata_q[CMD_FINISH] && (cal_st_q == CAL_IDLE);
   assign refuse = do_add && (cal_cnt_q >= CAL_IDX_W'(CAL_MAX));

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cal_cnt_q <= '0;
         for (int i = 0; i < CAL_MAX; i++) cal_q[i] <= '0;
      end else if (do_clr) begin
         cal_cnt_q <= '0;
      end else if (do_del) begin
         if (cal_cnt_q != '0) cal_cnt_q <= cal_cnt_q - 1'b1;
      end else if (do_add && !refuse) begin
         cal_q[cal_cnt_q] <= {cal_vol_q, 4'h0, level_q.level};
         cal_cnt_q        <= cal_cnt_q + 1'b1;
      end
   end

   assign nvm_out = nvm_q;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cal_st_q  <= CAL_IDLE;
         nvm_idx_q <= '0;
         nvm_q     <= '0;
      end else begin
         unique case (cal_st_q)
            CAL_IDLE: if (do_fin) begin
               nvm_idx_q <= '0;
               cal_st_q  <= CAL_ENTRY;
            end
            CAL_ENTRY: if (!nvm_q.valid || nvm_ready_in) begin
               if (nvm_idx_q < cal_cnt_q) begin
                  nvm_q     <= '{valid: 1'b1, addr: nvm_idx_q, data: cal_q[nvm_idx_q]};
                  nvm_idx_q <= nvm_idx_q + 1'b1;
               end else begin
                  nvm_q    <= '{valid: 1'b1, addr: NVM_HDR_ADDR, data: {27'h0, cal_cnt_q}};
                  cal_st_q <= CAL_HDR;
               end
            end
            CAL_HDR: if (nvm_ready_in) begin
               nvm_q.valid <= 1'b0;
               cal_st_q    <= CAL_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Interrupts
   // ---------------------------------------------------------------
   assign int_set[INT_STABLE] = pend_q && (stable_q != (stab_near && stab_cnt_q >= 8'(STAB_SAMPLES)));
   assign int_set[INT_REFUSE] = refuse;
   assign int_set[INT_COMMIT] = (cal_st_q == CAL_HDR) && nvm_ready_in;
   assign int_set[INT_ADDED]  = do_add && !refuse;
   assign irq_out    = |(int_q & mask_q);
   assign stable_out = stable_q;
   assign level_out  = level_q;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) int_q <= '0;
      else        int_q <= (int_q & ~{INT_W{int_rd}}) | int_set;
   end

endmodule : fll_filter_top

// [verilog/fll_pkg.sv]
// Shared constants, types and register map of the fuel level filter block
package fll_pkg;

   // ---------------------------------------------------------------
   // Widths and limits
   // ---------------------------------------------------------------
   localparam int LVL_W          = 12;
   localparam int ADDR_W         = 8;
   localparam int CAL_MAX        = 30;
   localparam int CAL_IDX_W      = 5;
   localparam int AVG_TIME_MAX_S = 21;
   localparam int MED_EXTRA_MIN  = 3;
   localparam int MED_DEPTH      = 10;
   localparam int ADP_FRAC       = 4;
   localparam int ADP_WSH        = 8;

   // ---------------------------------------------------------------
   // Register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_AVG     = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_MED     = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_COVQ    = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_COVR    = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_INT     = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_MASK    = 8'h1c;
   localparam logic [ADDR_W-1:0] OFS_CALCMD  = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_CALVOL  = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_LEVEL   = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_CALIDX  = 8'h2c;
   localparam logic [ADDR_W-1:0] OFS_CALDATA = 8'h30;

   // ---------------------------------------------------------------
   // Reset values and field positions
   // ---------------------------------------------------------------
   localparam logic [4:0]  AVG_TIME_RST = 5'h15;
   localparam logic [2:0]  MED_LEN_RST  = 3'h7;
   localparam logic [15:0] COV_RST      = 16'h0100;
   localparam int CMD_ADD    = 0;
   localparam int CMD_DEL    = 1;
   localparam int CMD_CLEAR  = 2;
   localparam int CMD_FINISH = 3;
   localparam int INT_W      = 4;
   localparam int INT_STABLE = 0;
   localparam int INT_REFUSE = 1;
   localparam int INT_COMMIT = 2;
   localparam int INT_ADDED  = 3;
   localparam logic [CAL_IDX_W-1:0] NVM_HDR_ADDR = 5'h1f;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {FLL_OFF, FLL_AVG, FLL_MED, FLL_ADP} fll_mode_e;

   typedef struct packed {
      logic             valid;
      logic [LVL_W-1:0] level;
   } fll_sample_s;

   typedef struct packed {
      logic                 valid;
      logic [CAL_IDX_W-1:0] addr;
      logic [31:0]          data;
   } fll_nvm_s;

endpackage : fll_pkg

// [verilog/fll_trim_mean.sv]
// Sliding window mean with the lowest and highest samples discarded
`timescale 1ns/1ns
module fll_trim_mean #(
   parameter int DEPTH = fll_pkg::MED_DEPTH
) (
   input  wire logic                     clk_in,
   input  wire logic                     rst_in,
   input  wire logic                     flush_in,
   input  wire fll_pkg::fll_sample_s     sample_in,
   input  wire logic [2:0]               len_in,
   output logic      [fll_pkg::LVL_W-1:0] mean_out
);
   import fll_pkg::*;

   logic [LVL_W-1:0] win_q [DEPTH];
   logic [3:0]       fill_q;
   logic [3:0]       span;
   logic [3:0]       used;
   logic [LVL_W+3:0] sum;
   logic [LVL_W-1:0] lo;
   logic [LVL_W-1:0] hi;

   assign span = 4'(len_in) + 4'(MED_EXTRA_MIN);
   assign used = (fill_q < span) ? fill_q : span;

   // ---------------------------------------------------------------
   // Window storage
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         fill_q <= 4'h0;
         for (int i = 0; i < DEPTH; i++) win_q[i] <= '0;
      end else if (flush_in) begin
         fill_q <= 4'h0;
      end else if (sample_in.valid) begin
         win_q[0] <= sample_in.level;
         for (int i = 1; i < DEPTH; i++) win_q[i] <= win_q[i-1];
         if (fill_q < 4'(DEPTH)) fill_q <= fill_q + 4'h1;
      end
   end

   // ---------------------------------------------------------------
   // Extremes dropped, rest averaged
   // ---------------------------------------------------------------
   always_comb begin
      sum = '0;
      lo  = '1;
      hi  = '0;
      for (int i = 0; i < DEPTH; i++) begin
         if (4'(i) < used) begin
            sum = sum + (LVL_W+4)'(win_q[i]);
            if (win_q[i] < lo) lo = win_q[i];
            if (win_q[i] > hi) hi = win_q[i];
         end
      end
      if (used < 4'(MED_EXTRA_MIN))
         mean_out = win_q[0];
      else
         mean_out = LVL_W'((sum - (LVL_W+4)'(lo) - (LVL_W+4)'(hi)) / (LVL_W+4)'(used - 4'h2));
   end

endmodule : fll_trim_mean
